//--- core/video_input_unit.sv
// full-resolution CCIR656 capture front end with clocking, reset and status
// Functional notes
// - power down with the chip unless keep-awake is set
// - with keep-awake, keep capturing and wake the host on interrupt events
// - control word 0x00080000 or the reset pin resets the unit
// - reset clears control, status and clock setup registers
// - external clock mode: pin is input, sampled via synchronizers, divider ignored
// - loopback with external clock uses the output unit's clock
// - internal mode drives the pin at core clock over divider
// - split stream from data pins into separate Y, U, V planes
// - co-sited mode passes chroma unchanged
// - interspersed mode filters chroma with taps -1 13 5 -1 over 16
// - filtered chroma saturates to 01h..FFh
// - mirror samples around first and last pixel of the line
// - first mirror pixel is the first U Y V group after SAV
// - EAV with multiple bit errors still ends the line and mirrors
// - correct single SAV errors, ignore double-error SAV codes
// - pixel index clears after SAV and counts later luma samples
// - line index clears on first V=0 SAV after V=1, else increments
// - second-field flag follows F of every decoded SAV
// - data valid qualifies each sampling edge
// - loopback only switches the input multiplexer
`default_nettype none
module video_input_unit
  import video_capture_pkg::*;
#(
  parameter int PIX_W = PIXEL_INDEX_W,
  parameter int LIN_W = LINE_INDEX_W,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // chip power management
  input  wire logic              global_power_down_i,
  input  wire logic              irq_event_i,
  output var  logic              power_down_o,
  output var  logic              wake_host_o,
  // register writes
  input  wire logic              control_write_i,
  input  wire logic [31:0]       control_word_i,
  input  wire logic              clock_write_i,
  input  wire logic [31:0]       clock_word_i,
  // video pins
  input  wire logic              video_clock_pin_i,
  output var  logic              video_clock_pin_o,
  output var  logic              video_clock_pin_oe_o,
  input  wire logic [7:0]        video_data_pins_i,
  input  wire logic              data_valid_pin_i,
  // output unit pins for loopback
  input  wire logic              loop_clock_i,
  input  wire logic [7:0]        loop_data_i,
  input  wire logic              loop_valid_i,
  // plane stream
  output var  logic              plane_valid_o,
  output var  plane_word_type    plane_word_o,
  input  wire logic              plane_ready_i,
  // status
  output var  logic [PIX_W-1:0]  pixel_index_o,
  output var  logic [LIN_W-1:0]  line_index_o,
  output var  logic              second_field_flag_o,
  output var  logic              overflow_o
);
  localparam int SYNC_W = 20;

  // decodes a status byte: {ok, f, v, h}
  function automatic logic [3:0] decode_trs(input logic [7:0] b);
    logic [3:0] res;
    logic [6:0] cw;
    logic [2:0] fvh;
    res = {1'b0, b[6:4]};
    for (int i = 0; i < 8; i++) begin
      fvh = 3'(i);
      cw  = {fvh, fvh[1] ^ fvh[0], fvh[2] ^ fvh[0], fvh[2] ^ fvh[1], ^fvh};
      if ($countones(cw ^ b[6:0]) <= 1) begin
        res = {1'b1, fvh};
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] chroma_tap(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] c, input logic [7:0] d);
    logic signed [14:0] acc;
    logic signed [14:0] sh;
    acc = $signed({7'h00, b}) * 15'sh00D + $signed({7'h00, c}) * 15'sh005
        - $signed({7'h00, a}) - $signed({7'h00, d});
    sh  = acc >>> 4;
    if (sh < $signed({7'h00, CHROMA_MIN})) begin
      return CHROMA_MIN;
    end else if (sh > $signed({7'h00, CHROMA_MAX})) begin
      return CHROMA_MAX;
    end
    return sh[7:0];
  endfunction

  logic                     rst_s1_q;
  logic                     rst_s2_q;
  logic                     rst_n;
  logic [SYNC_W-1:0]        sync1_q;
  logic [SYNC_W-1:0]        sync2_q;
  logic                     soft_rst;
  logic [31:0]              control_q;
  logic [31:0]              control_d;
  logic [31:0]              clock_setup_q;
  logic [31:0]              clock_setup_d;
  logic                     power_down_q;
  logic                     power_down_d;
  logic                     wake_q;
  logic                     wake_d;
  logic                     clk_prev_q;
  logic                     clk_prev_d;
  logic [CLK_DIVIDER_W-1:0] div_cnt_q;
  logic [CLK_DIVIDER_W-1:0] div_cnt_d;
  logic [CLK_DIVIDER_W-1:0] div_eff;
  logic                     vclk_q;
  logic                     vclk_d;
  logic                     rise_q;
  logic                     rise_d;
  logic                     internal_clock_select;
  logic                     loopback;
  logic                     clk_sel;
  logic                     valid_sel;
  logic [7:0]               data_sel;
  logic                     strobe;
  logic                     take;

  // reset release
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // pin synchronizers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {loop_clock_i, loop_valid_i, loop_data_i,
                  video_clock_pin_i, data_valid_pin_i, video_data_pins_i};
      sync2_q <= sync1_q;
    end
  end

  assign soft_rst              = control_write_i && (control_word_i == SOFT_RESET_WORD);
  assign internal_clock_select = clock_setup_q[CLK_SELECT_BIT];
  assign loopback              = control_q[CTL_LOOPBACK_BIT];
  assign clk_sel   = loopback ? sync2_q[19] : sync2_q[9];
  assign valid_sel = loopback ? sync2_q[18] : sync2_q[8];
  assign data_sel  = loopback ? sync2_q[17:10] : sync2_q[7:0];
  assign div_eff   = (clock_setup_q[CLK_DIVIDER_LSB +: CLK_DIVIDER_W] < 8'h02) ? 8'h02
                   : clock_setup_q[CLK_DIVIDER_LSB +: CLK_DIVIDER_W];

  // control, clock setup, power and clock generation
  always_comb begin
    control_d     = control_q;
    clock_setup_d = clock_setup_q;
    if (control_write_i) begin
      control_d = control_word_i;
    end
    if (clock_write_i) begin
      clock_setup_d = clock_word_i;
    end
    power_down_d = global_power_down_i & ~control_q[CTL_KEEP_AWAKE_BIT];
    wake_d = global_power_down_i & control_q[CTL_KEEP_AWAKE_BIT] & irq_event_i;
    clk_prev_d = clk_sel;
    if (internal_clock_select) begin
      div_cnt_d = (div_cnt_q >= div_eff - 8'h01) ? 8'h00 : div_cnt_q + 8'h01;
    end else begin
      div_cnt_d = 8'h00;
    end
    vclk_d = internal_clock_select && (div_cnt_d < (div_eff >> 1));
    rise_d = internal_clock_select && (div_cnt_d == 8'h00);
    if (soft_rst) begin
      control_d     = CTL_RESET_VALUE;
      clock_setup_d = CLK_RESET_VALUE;
      div_cnt_d     = 8'h00;
      vclk_d        = 1'b0;
      rise_d        = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      control_q     <= CTL_RESET_VALUE;
      clock_setup_q <= CLK_RESET_VALUE;
      power_down_q  <= 1'b0;
      wake_q        <= 1'b0;
      clk_prev_q    <= 1'b0;
      div_cnt_q     <= 8'h00;
      vclk_q        <= 1'b0;
      rise_q        <= 1'b0;
    end else begin
      control_q     <= control_d;
      clock_setup_q <= clock_setup_d;
      power_down_q  <= power_down_d;
      wake_q        <= wake_d;
      clk_prev_q    <= clk_prev_d;
      div_cnt_q     <= div_cnt_d;
      vclk_q        <= vclk_d;
      rise_q        <= rise_d;
    end
  end

  assign strobe = internal_clock_select ? rise_q : (clk_sel & ~clk_prev_q);
  assign take   = strobe & valid_sel & ~power_down_q;

  // stream parser state
  line_state_type      state_q;
  line_state_type      state_d;
  logic [1:0]          pre_q;
  logic [1:0]          pre_d;
  logic [1:0]          phase_q;
  logic [1:0]          phase_d;
  logic [PIX_W-1:0]    pix_q;
  logic [PIX_W-1:0]    pix_d;
  logic [LIN_W-1:0]    line_q;
  logic [LIN_W-1:0]    line_d;
  logic                field_q;
  logic                field_d;
  logic                last_v_q;
  logic                last_v_d;
  logic                first_y_q;
  logic                first_y_d;
  logic [7:0]          hist_q [2][3];
  logic [7:0]          hist_d [2][3];
  logic [1:0]          ccnt_q [2];
  logic [1:0]          ccnt_d [2];
  logic [1:0]          flush_q;
  logic [1:0]          flush_d;
  logic                overflow_q;
  logic                overflow_d;
  logic                emit;
  plane_word_type      emit_word;
  logic                buf_ready;
  logic                siting;
  logic                capture_on;
  logic [3:0]          dec;
  logic                chan;

  assign siting     = control_q[CTL_SITING_BIT];
  assign capture_on = control_q[CTL_CAPTURE_BIT];

  always_comb begin
    state_d   = state_q;
    pre_d     = pre_q;
    phase_d   = phase_q;
    pix_d     = pix_q;
    line_d    = line_q;
    field_d   = field_q;
    last_v_d  = last_v_q;
    first_y_d = first_y_q;
    hist_d    = hist_q;
    ccnt_d    = ccnt_q;
    flush_d   = flush_q;
    overflow_d = overflow_q;
    emit      = 1'b0;
    emit_word = '{plane: PLANE_Y, sample: 8'h00};
    dec       = decode_trs(data_sel);
    chan      = phase_q[1];
    if (state_q == ST_FLUSH) begin
      if (buf_ready || !capture_on) begin
        emit = 1'b1;
        emit_word.plane = flush_q[0] ? PLANE_V : PLANE_U;
        if (!flush_q[1]) begin
          emit_word.sample = chroma_tap(hist_q[flush_q[0]][2], hist_q[flush_q[0]][1],
                                        hist_q[flush_q[0]][0], hist_q[flush_q[0]][1]);
        end else begin
          emit_word.sample = chroma_tap(hist_q[flush_q[0]][1], hist_q[flush_q[0]][0],
                                        hist_q[flush_q[0]][1], hist_q[flush_q[0]][2]);
        end
        flush_d = flush_q + 2'h1;
        if (flush_q == 2'h3) begin
          state_d = ST_BLANK;
        end
      end
    end
    if (take) begin
      if (pre_q == 2'h3) begin
        pre_d = 2'h0;
        if (dec[3] && !dec[0]) begin
          state_d   = ST_ACTIVE;
          phase_d   = 2'h0;
          pix_d     = '0;
          first_y_d = 1'b1;
          field_d   = dec[2];
          line_d    = (!dec[1] && last_v_q) ? '0 : line_q + 1'b1;
          last_v_d  = dec[1];
          ccnt_d[0] = 2'h0;
          ccnt_d[1] = 2'h0;
        end else if ((dec[3] ? dec[0] : data_sel[4]) && state_q == ST_ACTIVE) begin
          flush_d = 2'h0;
          state_d = (siting && ccnt_q[0] == 2'h3 && ccnt_q[1] == 2'h3) ? ST_FLUSH
                  : ST_BLANK;
        end
      end else if (data_sel == TRS_FIRST) begin
        pre_d = 2'h1;
      end else if (pre_q != 2'h0 && data_sel == TRS_ZERO) begin
        pre_d = pre_q + 2'h1;
      end else begin
        pre_d = 2'h0;
        if (state_q == ST_ACTIVE) begin
          phase_d = phase_q + 2'h1;
          if (phase_q[0]) begin
            emit      = 1'b1;
            emit_word = '{plane: PLANE_Y, sample: data_sel};
            first_y_d = 1'b0;
            if (!first_y_q) begin
              pix_d = pix_q + 1'b1;
            end
          end else begin
            if (!siting) begin
              emit = 1'b1;
              emit_word = '{plane: chan ? PLANE_V : PLANE_U, sample: data_sel};
            end else if (ccnt_q[chan] >= 2'h2) begin
              emit = 1'b1;
              emit_word.plane  = chan ? PLANE_V : PLANE_U;
              emit_word.sample = chroma_tap((ccnt_q[chan] == 2'h2) ? hist_q[chan][0]
                                            : hist_q[chan][2], hist_q[chan][1],
                                            hist_q[chan][0], data_sel);
            end
            hist_d[chan][2] = hist_q[chan][1];
            hist_d[chan][1] = hist_q[chan][0];
            hist_d[chan][0] = data_sel;
            if (ccnt_q[chan] != 2'h3) begin
              ccnt_d[chan] = ccnt_q[chan] + 2'h1;
            end
          end
        end
      end
    end
    if (emit && capture_on && !buf_ready) begin
      overflow_d = 1'b1;
    end
    if (soft_rst) begin
      state_d    = ST_BLANK;
      pre_d      = 2'h0;
      phase_d    = 2'h0;
      pix_d      = '0;
      line_d     = '0;
      field_d    = 1'b0;
      last_v_d   = 1'b0;
      first_y_d  = 1'b0;
      flush_d    = 2'h0;
      overflow_d = 1'b0;
      emit       = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_BLANK;
      pre_q      <= 2'h0;
      phase_q    <= 2'h0;
      pix_q      <= '0;
      line_q     <= '0;
      field_q    <= 1'b0;
      last_v_q   <= 1'b0;
      first_y_q  <= 1'b0;
      flush_q    <= 2'h0;
      overflow_q <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        ccnt_q[c] <= 2'h0;
        for (int k = 0; k < 3; k++) begin
          hist_q[c][k] <= 8'h00;
        end
      end
    end else begin
      state_q    <= state_d;
      pre_q      <= pre_d;
      phase_q    <= phase_d;
      pix_q      <= pix_d;
      line_q     <= line_d;
      field_q    <= field_d;
      last_v_q   <= last_v_d;
      first_y_q  <= first_y_d;
      flush_q    <= flush_d;
      overflow_q <= overflow_d;
      ccnt_q     <= ccnt_d;
      hist_q     <= hist_d;
    end
  end

  plane_buffer #(
    .WIDTH ($bits(plane_word_type)),
    .DEPTH (BUF_DEPTH)
  ) u_plane_buffer (
    .clk_i     (mclk_i),
    .rst_n_i   (rst_n),
    .s_valid_i (emit & capture_on),
    .s_data_i  (emit_word),
    .s_ready_o (buf_ready),
    .m_valid_o (plane_valid_o),
    .m_data_o  (plane_word_o),
    .m_ready_i (plane_ready_i)
  );

  assign power_down_o         = power_down_q;
  assign wake_host_o          = wake_q;
  assign video_clock_pin_o    = vclk_q;
  assign video_clock_pin_oe_o = internal_clock_select;
  assign pixel_index_o        = pix_q;
  assign line_index_o         = line_q;
  assign second_field_flag_o  = field_q;
  assign overflow_o           = overflow_q;
endmodule
`default_nettype wire

//--- core/video_capture_pkg.sv
// shared constants and types of the full-resolution video capture front end
`default_nettype none
package video_capture_pkg;
  // control word layout
  localparam logic [31:0] SOFT_RESET_WORD    = 32'h0008_0000;
  localparam int          CTL_CAPTURE_BIT    = 0;
  localparam int          CTL_SITING_BIT     = 1;
  localparam int          CTL_LOOPBACK_BIT   = 2;
  localparam int          CTL_KEEP_AWAKE_BIT = 3;
  localparam logic [31:0] CTL_RESET_VALUE    = 32'h0000_0000;
  // clock setup word layout
  localparam int          CLK_SELECT_BIT     = 0;
  localparam int          CLK_DIVIDER_LSB    = 8;
  localparam int          CLK_DIVIDER_W      = 8;
  localparam logic [31:0] CLK_RESET_VALUE    = 32'h0000_0000;
  // timing reference bytes and chroma saturation limits
  localparam logic [7:0]  TRS_FIRST          = 8'hFF;
  localparam logic [7:0]  TRS_ZERO           = 8'h00;
  localparam logic [7:0]  CHROMA_MIN         = 8'h01;
  localparam logic [7:0]  CHROMA_MAX         = 8'hFF;
  // status widths
  localparam int          PIXEL_INDEX_W      = 11;
  localparam int          LINE_INDEX_W       = 10;
  // output plane codes
  typedef enum logic [1:0] {
    PLANE_Y = 2'h0,
    PLANE_U = 2'h1,
    PLANE_V = 2'h2
  } plane_type;
  typedef struct packed {
    plane_type  plane;
    logic [7:0] sample;
  } plane_word_type;
  // line framing states
  typedef enum logic [2:0] {
    ST_BLANK  = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_FLUSH  = 3'b100
  } line_state_type;
endpackage
`default_nettype wire

//--- core/plane_buffer.sv
// shift-register buffer with valid and ready on both sides
`default_nettype none
module plane_buffer
  import video_capture_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // filling side
  input  wire logic             s_valid_i,
  input  wire logic [WIDTH-1:0] s_data_i,
  output var  logic             s_ready_o,
  // draining side
  output var  logic             m_valid_o,
  output var  logic [WIDTH-1:0] m_data_o,
  input  wire logic             m_ready_i
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] valid_q;
  logic [DEPTH-1:0] valid_d;
  logic             push;
  logic             pop;
  logic             placed;

  always_comb begin
    pop  = valid_q[0] & m_ready_i;
    push = s_valid_i & ~valid_q[DEPTH-1];
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i]   = mem_q[i];
      valid_d[i] = valid_q[i];
    end
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_d[i]   = mem_q[i+1];
        valid_d[i] = valid_q[i+1];
      end
      valid_d[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!valid_d[i] && !placed) begin
          mem_d[i]   = s_data_i;
          valid_d[i] = 1'b1;
          placed     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      valid_q <= valid_d;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign s_ready_o = ~valid_q[DEPTH-1];
  assign m_valid_o = valid_q[0];
  assign m_data_o  = mem_q[0];
endmodule
`default_nettype wire

//--- bench/video_source_model.sv
// camera side model driving a CCIR656 byte stream
`default_nettype none
module video_source (
  // pacing clock
  input  wire logic       mclk_i,
  // link pins
  output var  logic       clk_o,
  output var  logic [7:0] data_o,
  output var  logic       valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    clk_o = 1'b0;
    data_o = 8'h00;
    valid_o = 1'b0;
  end
  // one byte per slow clock, data set while the clock is low
  task automatic put(input logic [7:0] b, input logic v);
    @(posedge mclk_i);
    data_o <= b;
    valid_o <= v;
    repeat (3) @(posedge mclk_i);
    clk_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    clk_o <= 1'b0;
  endtask
  // timing reference: preamble then status byte
  task automatic code(input logic [7:0] s);
    put(8'hFF, 1'b1);
    put(8'h00, 1'b1);
    put(8'h00, 1'b1);
    put(s, 1'b1);
  endtask
  // between lines the clock stands still and data shows no stale value
  task automatic idle();
    @(posedge mclk_i);
    valid_o <= 1'b0;
    data_o <= ~data_o;
  endtask
  // running clock without data
  task automatic run(input int n);
    repeat (n) put(~data_o, 1'b0);
  endtask
endmodule
`default_nettype wire

//--- bench/video_input_assertions.sv
// port-level checks of the capture front end
`default_nettype none
module video_input_assertions
  import video_capture_pkg::*;
#(
  parameter int PIX_W = PIXEL_INDEX_W,
  parameter int LIN_W = LINE_INDEX_W
) (
  input wire logic mclk_i, resetn_i, global_power_down_i, irq_event_i,
  input wire logic power_down_o, wake_host_o, control_write_i, clock_write_i,
  input wire logic [31:0] control_word_i, clock_word_i,
  input wire logic video_clock_pin_oe_o, plane_valid_o, plane_ready_i,
  input wire logic second_field_flag_o, overflow_o,
  input wire plane_word_type plane_word_o,
  input wire logic [PIX_W-1:0] pixel_index_o,
  input wire logic [LIN_W-1:0] line_index_o
);
  logic soft_w, sel_w;
  assign soft_w = control_write_i && control_word_i == SOFT_RESET_WORD;
  assign sel_w = clock_word_i[CLK_SELECT_BIT];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  pd_follow_a: assert property (!global_power_down_i |=> !power_down_o)
    else $error("unit powered down without a global request");
  wake_cause_a: assert property (wake_host_o |->
    $past(global_power_down_i) && $past(irq_event_i) && !power_down_o)
    else $error("host wake without cause");
  soft_clear_a: assert property (soft_w && !clock_write_i |=>
    !video_clock_pin_oe_o && pixel_index_o == '0 && line_index_o == '0
    && !second_field_flag_o && !overflow_o) else $error("soft reset left state");
  oe_set_a: assert property (clock_write_i && !soft_w |=>
    video_clock_pin_oe_o == $past(sel_w)) else $error("pin direction wrong");
  oe_hold_a: assert property (!clock_write_i && !soft_w |=>
    $stable(video_clock_pin_oe_o)) else $error("pin direction changed");
  word_hold_a: assert property (plane_valid_o && !plane_ready_i |=>
    plane_valid_o && $stable(plane_word_o)) else $error("stalled word changed");
  plane_code_a: assert property (plane_valid_o |-> plane_word_o.plane != 2'h3)
    else $error("unknown plane code");
  ovf_hold_a: assert property (overflow_o && !soft_w |=> overflow_o)
    else $error("overflow flag dropped");
endmodule
bind video_input_unit video_input_assertions #(.PIX_W(PIX_W), .LIN_W(LIN_W)) chk (
  .mclk_i, .resetn_i, .global_power_down_i, .irq_event_i, .power_down_o,
  .wake_host_o, .control_write_i, .clock_write_i, .control_word_i, .clock_word_i,
  .video_clock_pin_oe_o, .plane_valid_o, .plane_ready_i, .second_field_flag_o,
  .overflow_o, .plane_word_o, .pixel_index_o, .line_index_o);
`default_nettype wire

//--- bench/video_input_unit_bench.sv
// self-checking bench of the capture front end
`default_nettype none
module video_input_unit_bench
  import video_capture_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0, resetn_i = 1'b0, gpd = 1'b0, irq = 1'b0, lb = 1'b0;
  logic        cw = 1'b0, kw = 1'b0, rdy = 1'b1;
  logic [31:0] cword = '0, kword = '0, seed = 32'hF200;
  logic        pd, wake, pin_o, oe, pv, ovf, fld, s_clk, s_val;
  logic [7:0]  s_dat;
  logic [10:0] pix;
  logic [9:0]  lin;
  plane_word_type pw;
  int          err_count = 0, checked = 0, track = 0, sc = 0, ext = 0, rnd = 0, hold = 0;
  int          exq[3][$];
  always #5 mclk_i = ~mclk_i;
  video_source src (.mclk_i(mclk_i), .clk_o(s_clk), .data_o(s_dat), .valid_o(s_val));
  video_input_unit DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .global_power_down_i(gpd), .irq_event_i(irq),
    .power_down_o(pd), .wake_host_o(wake), .control_write_i(cw), .control_word_i(cword),
    .clock_write_i(kw), .clock_word_i(kword),
    .video_clock_pin_i(oe ? pin_o : (s_clk & ~lb)), .video_clock_pin_o(pin_o),
    .video_clock_pin_oe_o(oe), .video_data_pins_i(lb ? ~s_dat : s_dat),
    .data_valid_pin_i(s_val & ~lb), .loop_clock_i(s_clk & lb),
    .loop_data_i(lb ? s_dat : ~s_dat), .loop_valid_i(s_val & lb), .plane_valid_o(pv),
    .plane_word_o(pw), .plane_ready_i(rdy), .pixel_index_o(pix), .line_index_o(lin),
    .second_field_flag_o(fld), .overflow_o(ovf));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] trs(input logic f, v, h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction
  function automatic int filt(input int a, b, c, d);
    int r;
    r = (-a + 13 * b + 5 * c - d) >>> 4;
    return r < 1 ? 1 : (r > 255 ? 255 : r);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic wr(input logic clk_reg, input logic [31:0] w);
    @(posedge mclk_i);
    kw <= clk_reg;
    cw <= ~clk_reg;
    kword <= w;
    cword <= w;
    @(posedge mclk_i);
    cw <= 1'b0;
    kw <= 1'b0;
    @(posedge mclk_i);
  endtask
  // one line: SAV, n groups of U Y V Y, EAV, with expected planes
  task automatic sl(input logic f, v, input int n, input logic [7:0] sm, em, input int live);
    int c[2][$];
    int p, k;
    logic [7:0] b;
    track = live;
    src.code(trs(f, v, 1'b0) ^ sm);
    for (int i = 0; i < 4 * n; i++) begin
      p = i % 2 ? 0 : (i % 4 == 0 ? 1 : 2);
      b = 8'h01 + 8'(seed % 254);
      if (ext != 0 && p != 0) b = (i / 4) % 4 inside {1, 2} ? 8'h01 : 8'hFE;
      if (i == 2) src.put(8'hFF, 1'b0);
      src.put(b, 1'b1);
      if (p == 0 || sc == 0) exq[p].push_back(b);
      else begin
        c[p-1].push_back(b);
        k = c[p-1].size() - 3;
        if (k >= 0) exq[p].push_back(filt(c[p-1][k == 0 ? 1 : k - 1], c[p-1][k],
                                          c[p-1][k+1], c[p-1][k+2]));
      end
    end
    src.code(trs(f, v, 1'b1) ^ em);
    src.idle();
    if (sc != 0 && n >= 3) begin
      for (int q = 0; q < 2; q++) begin
        exq[q+1].push_back(filt(c[q][n-3], c[q][n-2], c[q][n-1], c[q][n-2]));
        exq[q+1].push_back(filt(c[q][n-2], c[q][n-1], c[q][n-2], c[q][n-3]));
      end
    end
    if (live == 0) foreach (exq[j]) exq[j].delete();
    for (int t = 0; t < 300 && (pv === 1'b1 || exq[0].size() + exq[1].size()
         + exq[2].size() > 0); t++) @(negedge mclk_i);
    check("left over", exq[0].size() + exq[1].size() + exq[2].size(), 0);
    if (live != 0) check("pixel index", pix, 2 * n - 1);
  endtask
  always @(posedge mclk_i) begin
    if (track != 0 && pv === 1'b1 && rdy === 1'b1) begin
      if (exq[pw.plane].size() == 0) check("spare word", pw, 32'hFFFF);
      else check("plane sample", pw.sample, exq[pw.plane].pop_front());
    end
    seed <= xs(seed);
    rdy <= hold != 0 ? 1'b0 : (rnd == 0 || seed[3] || seed[9]);
  end
  initial begin
    int t0, t1;
    logic prv;
    t0 = 0;
    t1 = 0;
    prv = 1'b0;
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    tick(3);
    check("reset state", {pd, wake, pin_o, oe, pv, ovf, fld, pix, lin}, 0);
    @(posedge mclk_i);
    gpd <= 1'b1;
    irq <= 1'b1;
    tick(3);
    check("power down", {pd, wake}, 2'b10);
    wr(0, 32'h8);
    tick(1);
    check("keep awake", {pd, wake}, 2'b01);
    @(posedge mclk_i);
    gpd <= 1'b0;
    irq <= 1'b0;
    wr(0, 32'h1);
    sl(1, 1, 2, 8'h00, 8'h00, 0);
    sl(1, 0, 4, 8'h00, 8'h00, 1);
    check("line field", {lin, fld}, 11'h001);
    sl(0, 0, 3, 8'h40, 8'h03, 1);
    check("line field", {lin, fld}, 11'h002);
    sl(1, 0, 2, 8'h03, 8'h00, 0);
    check("line field", {lin, fld}, 11'h002);
    sc = 1;
    rnd = 1;
    wr(0, 32'h3);
    sl(1, 0, 2, 8'h00, 8'h00, 1);
    ext = 1;
    sl(1, 0, 6, 8'h00, 8'h00, 1);
    ext = 0;
    sl(0, 0, 5, 8'h00, 8'h00, 1);
    check("overflow", ovf, 0);
    hold = 1;
    sl(1, 0, 4, 8'h00, 8'h00, 0);
    check("overflow", ovf, 1);
    hold = 0;
    for (int t = 0; t < 50 && pv !== 1'b0; t++) @(negedge mclk_i);
    wr(1, 32'h0000_0401);
    for (int t = 0; t < 30; t++) begin
      @(negedge mclk_i);
      if (pin_o && !prv) t0 = t1;
      if (pin_o && !prv) t1 = t;
      prv = pin_o;
    end
    check("clock period", t1 - t0, 4);
    check("pin driven", oe, 1);
    fork
      src.run(6);
      wr(0, SOFT_RESET_WORD);
    join
    tick(1);
    check("soft reset", {oe, ovf, fld, pix, lin}, 0);
    src.run(5);
    @(posedge mclk_i);
    lb <= 1'b1;
    sc = 0;
    wr(0, 32'h5);
    sl(1, 0, 3, 8'h00, 8'h00, 1);
    check("line field", {lin, fld}, 11'h003);
    conclude();
  end
  initial begin
    repeat (50000) @(posedge mclk_i);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
